// ### rtl/smcd_decoder.sv
`timescale 1ns/1ps
module smcd_decoder (
  input  wire logic        mclk_i,
  input  wire logic        arst_n_i,
  input  wire logic [63:0] msg_i,
  input  wire logic        msg_valid_i,
  input  wire logic [31:0] present_pos_i,
  input  wire logic        abs_system_i,
  input  wire logic        intr_in_i,
  input  wire logic        motion_done_i,
  input  wire logic [2:0]  origin_search_mode_sel_i,
  input  wire logic        home_dir_i,
  input  wire logic [17:0] interrupt_position_speed_i,
  input  wire logic [31:0] interrupt_feed_distance_i,
  input  wire logic        interrupt_feed_function_sel_i,
  input  wire logic [9:0]  exp_curve_time_constant_i,
  input  wire logic [9:0]  moving_avg_time_constant_i,
  output logic             move_start_o,
  output logic [2:0]       move_kind_o,
  output logic             busy_o,
  output logic [31:0]      target_o,
  output logic             dir_o,
  output logic [2:0]       search_mode_o,
  output logic [17:0]      crawl_speed_o,
  output logic [9:0]       exp_tc_o,
  output logic [9:0]       mavg_tc_o,
  output logic             ifeed_en_o,
  output logic             cmd_reject_o
);
  // ---------------------------------------------
  // message fields
  // ---------------------------------------------
  logic [7:0] b0, b1, b2, b3;
  logic [31:0] pos_val;
  logic servo_on, start_bit, home_bit, rel_bit, dir_bit;
  logic [3:0] code;
  assign b0 = msg_i[7:0];
  assign b1 = msg_i[15:8];
  assign b2 = msg_i[23:16];
  assign b3 = msg_i[31:24];
  assign pos_val   = msg_i[63:32];
  assign servo_on  = b0[smcd_pkg::SERVO_BIT];
  assign start_bit = b0[smcd_pkg::START_BIT];
  assign home_bit  = b2[smcd_pkg::HOME_BIT];
  assign rel_bit   = b3[smcd_pkg::REL_BIT];
  assign dir_bit   = b3[smcd_pkg::DIR_BIT];
  assign code      = b1[smcd_pkg::CODE_LSB +: smcd_pkg::CODE_W];

  // ---------------------------------------------
  // interrupt input synchroniser
  // ---------------------------------------------
  logic intr_s1_q, intr_s2_q, intr_s3_q;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      intr_s1_q <= 1'b0;
      intr_s2_q <= 1'b0;
      intr_s3_q <= 1'b0;
    end else begin
      intr_s1_q <= intr_in_i;
      intr_s2_q <= intr_s1_q;
      intr_s3_q <= intr_s2_q;
    end
  end
  logic intr_chg;
  assign intr_chg = intr_s2_q ^ intr_s3_q;

  // ---------------------------------------------
  // parameter clamps
  // ---------------------------------------------
  logic [17:0] ispeed_c;
  logic [9:0]  exp_c, mavg_c;
  smcd_clamp #(.W(18)) u_ispeed (
    .val_i (interrupt_position_speed_i),
    .lo_i  (smcd_pkg::SPEED_MIN),
    .hi_i  (smcd_pkg::SPEED_MAX),
    .val_o (ispeed_c)
  ); // see [RL13]
  smcd_clamp #(.W(10)) u_exp (
    .val_i (exp_curve_time_constant_i),
    .lo_i  (smcd_pkg::TC_MIN),
    .hi_i  (smcd_pkg::TC_MAX),
    .val_o (exp_c)
  ); // see [RL15]
  smcd_clamp #(.W(10)) u_mavg (
    .val_i (moving_avg_time_constant_i),
    .lo_i  (smcd_pkg::TC_MIN),
    .hi_i  (smcd_pkg::TC_MAX),
    .val_o (mavg_c)
  ); // see [RL16]

  // ---------------------------------------------
  // power-up latched feed selection
  // ---------------------------------------------
  logic ifeed_en_q, ifeed_en_d, pwr_seen_q, pwr_seen_d;
  always_comb begin
    pwr_seen_d = 1'b1;
    ifeed_en_d = pwr_seen_q ? ifeed_en_q : interrupt_feed_function_sel_i; // see [RL14]
  end
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pwr_seen_q <= 1'b0;
      ifeed_en_q <= smcd_pkg::IFEED_SEL_DEF;
    end else begin
      pwr_seen_q <= pwr_seen_d;
      ifeed_en_q <= ifeed_en_d;
    end
  end

  // ---------------------------------------------
  // command decode and motion state
  // ---------------------------------------------
  smcd_pkg::smcd_mv_t kind_q, kind_d;
  logic start_prev_q, start_prev_d, home_prev_q, home_prev_d;
  logic go_q, go_d, rej_q, rej_d, dir_q, dir_d;
  logic [31:0] tgt_q, tgt_d;
  logic [2:0] mode_q, mode_d;
  logic start_edge, home_edge;
  // start flag only counts as edge across valid message updates
  assign start_edge = msg_valid_i & start_bit & ~start_prev_q;                  // see [RL7]
  assign home_edge  = msg_valid_i & home_bit & ~home_prev_q;                    // see [RL2]

  always_comb begin
    kind_d       = kind_q;
    start_prev_d = msg_valid_i ? start_bit : start_prev_q;
    home_prev_d  = msg_valid_i ? home_bit : home_prev_q;
    go_d         = 1'b0;
    rej_d        = 1'b0;
    dir_d        = dir_q;
    tgt_d        = tgt_q;
    mode_d       = mode_q;
    if (kind_q != smcd_pkg::MV_IDLE && motion_done_i) begin
      kind_d = smcd_pkg::MV_IDLE;
    end
    if (kind_q == smcd_pkg::MV_IFEED && intr_chg) begin
      kind_d = smcd_pkg::MV_ICRP;                                               // see [RL11]
      tgt_d  = present_pos_i + interrupt_feed_distance_i;                       // see [RL11]
      go_d   = 1'b1;
    end
    if ((home_edge || start_edge) && !servo_on) begin
      rej_d = 1'b1;                                                             // see [RL17]
    end else if (home_edge) begin
      go_d   = 1'b1;
      mode_d = (origin_search_mode_sel_i > smcd_pkg::MODE_MAX) ? smcd_pkg::MODE_MAX
                                                               : origin_search_mode_sel_i; // see [RL3]
      dir_d  = home_dir_i;                                                      // see [RL3]
      kind_d = abs_system_i ? smcd_pkg::MV_HOMEP : smcd_pkg::MV_HOME;           // see [RL4]
      tgt_d  = abs_system_i ? 32'h0000_0000 : tgt_q;                            // see [RL4]
    end else if (start_edge) begin
      unique case (code)
        smcd_pkg::CODE_DIRECT: begin
          go_d   = 1'b1;
          kind_d = smcd_pkg::MV_POS;                                            // see [RL6]
          tgt_d  = rel_bit ? present_pos_i + pos_val : pos_val;                 // see [RL8]
          dir_d  = dir_bit;
        end
        smcd_pkg::CODE_IFEED: begin
          go_d   = 1'b1;
          kind_d = smcd_pkg::MV_IFEED;                                          // see [RL10]
          tgt_d  = rel_bit ? present_pos_i + pos_val : pos_val;                 // see [RL8]
          dir_d  = dir_bit;
        end
        default: begin
          rej_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      kind_q       <= smcd_pkg::MV_IDLE;
      start_prev_q <= 1'b0;
      home_prev_q  <= 1'b0;
      go_q         <= 1'b0;
      rej_q        <= 1'b0;
      dir_q        <= 1'b0;
      tgt_q        <= 32'h0000_0000;
      mode_q       <= 3'h0;
    end else begin
      kind_q       <= kind_d;
      start_prev_q <= start_prev_d;
      home_prev_q  <= home_prev_d;
      go_q         <= go_d;
      rej_q        <= rej_d;
      dir_q        <= dir_d;
      tgt_q        <= tgt_d;
      mode_q       <= mode_d;
    end
  end

  // ---------------------------------------------
  // outputs
  // ---------------------------------------------
  // ramps are not exposed separately: feeding shares positioning ramps
  assign move_start_o  = go_q;
  assign move_kind_o   = kind_q;
  assign busy_o        = (kind_q != smcd_pkg::MV_IDLE);
  assign target_o      = tgt_q;
  assign dir_o         = dir_q;
  assign search_mode_o = mode_q;
  assign crawl_speed_o = ispeed_c;
  assign exp_tc_o      = exp_c;                                                 // see [RL12]
  assign mavg_tc_o     = mavg_c;
  assign ifeed_en_o    = ifeed_en_q;
  assign cmd_reject_o  = rej_q;

  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  // accepted code launch: start edge, servo on, no origin request beside it
  sequence launch_ok_s;
    start_edge && servo_on && !home_edge;
  endsequence

  // a crawl switch in the same cycle is not a request, so it is left out
  servo_gate_a: assert property ((home_edge || start_edge) && !servo_on && !intr_chg // see [RL17]
    |=> !move_start_o && cmd_reject_o) else $error("motion launched without servo on");
  direct_launch_a: assert property (launch_ok_s ##0 (code == smcd_pkg::CODE_DIRECT) // see [RL6]
    |=> move_start_o && move_kind_o == smcd_pkg::MV_POS) else $error("direct positioning not launched");
  rel_target_a: assert property (launch_ok_s ##0 (code == smcd_pkg::CODE_DIRECT && rel_bit) // see [RL8]
    |=> target_o == $past(present_pos_i) + $past(pos_val)) else $error("relative target wrong");
  ifeed_launch_a: assert property (launch_ok_s ##0 (code == smcd_pkg::CODE_IFEED) // see [RL10]
    |=> move_kind_o == smcd_pkg::MV_IFEED) else $error("interrupt feeding not selected");
  no_level_start_a: assert property (msg_valid_i && start_bit && start_prev_q // see [RL7]
    && !home_edge && !intr_chg |=> !move_start_o) else $error("start level relaunched");
  home_abs_a: assert property (home_edge && servo_on && abs_system_i // see [RL4]
    |=> move_kind_o == smcd_pkg::MV_HOMEP && target_o == 32'h0000_0000) else $error("abs origin move wrong");
  home_launch_a: assert property (home_edge && servo_on |=> move_start_o && dir_o == $past(home_dir_i)) // see [RL2]
    else $error("origin search not started");
  crawl_switch_a: assert property (move_kind_o == smcd_pkg::MV_IFEED && intr_chg // see [RL11]
    && !home_edge && !start_edge |=> move_kind_o == smcd_pkg::MV_ICRP) else $error("interrupt change ignored");
  ispeed_range_a: assert property (crawl_speed_o >= smcd_pkg::SPEED_MIN // see [RL13]
    && crawl_speed_o <= smcd_pkg::SPEED_MAX) else $error("interrupt speed out of range");
  tc_range_a: assert property (exp_tc_o >= smcd_pkg::TC_MIN && exp_tc_o <= smcd_pkg::TC_MAX // see [RL15] [RL16]
    && mavg_tc_o >= smcd_pkg::TC_MIN && mavg_tc_o <= smcd_pkg::TC_MAX)
    else $error("time constant out of range");
  feed_sel_a: assert property (pwr_seen_q |=> $stable(ifeed_en_o)) else $error("feed select changed live"); // see [RL14]
endmodule : smcd_decoder

// ### include/smcd_pkg.sv
// Notes on behaviour
// [RL1] master sets servo-on, byte 0 bit 1, before any motion command
// [RL2] byte 2 bit 7 set requests origin search; device starts it
// [RL3] origin search drives configured direction using the selected search mode
// [RL4] with absolute detection, origin search becomes a positioning move to origin
// [RL5] master writes command code zero in byte 1 bits 0-3 first
// [RL6] code 0001 is direct positioning to the message target
// [RL7] code commands launch only on a rising edge of byte 0 bit 0
// [RL8] byte 3 bit 0 relative: target equals present position plus message value
// [RL9] master loads target bytes 4-7 before raising the start flag
// [RL10] code 0010 is interrupt feeding toward the target
// [RL11] interrupt input change: slow to interrupt speed, travel feed distance from there
// [RL12] interrupt feeding reuses ordinary positioning ramp settings
// [RL13] interrupt positioning speed 1 to 240000, default 24000, immediate
// [RL14] interrupt feed function select 0 or 1, default 0, power-up effective
// [RL15] exponential time constant 4 to 1000 ms, default 25, immediate
// [RL16] moving average time constant 4 to 1000 ms, default 25, immediate
// [RL17] origin requests and start edges ignored while servo-on is zero
package smcd_pkg;
  // ---------------------------------------------
  // message field positions
  // ---------------------------------------------
  localparam int unsigned START_BIT   = 0;
  localparam int unsigned SERVO_BIT   = 1;
  localparam int unsigned HOME_BIT    = 7;
  localparam int unsigned REL_BIT     = 0;
  localparam int unsigned DIR_BIT     = 1;
  localparam int unsigned CODE_LSB    = 0;
  localparam int unsigned CODE_W      = 4;
  // ---------------------------------------------
  // command codes
  // ---------------------------------------------
  localparam logic [3:0] CODE_NOP     = 4'h0;
  localparam logic [3:0] CODE_DIRECT  = 4'h1;
  localparam logic [3:0] CODE_IFEED   = 4'h2;
  // ---------------------------------------------
  // parameter ranges and defaults
  // ---------------------------------------------
  localparam logic [17:0] SPEED_MIN   = 18'h0_0001;
  localparam logic [17:0] SPEED_MAX   = 18'h3_A980;
  localparam logic [17:0] ISPEED_DEF  = 18'h0_5DC0;
  localparam logic [9:0]  TC_MIN      = 10'h004;
  localparam logic [9:0]  TC_MAX      = 10'h3E8;
  localparam logic [9:0]  TC_DEF      = 10'h019;
  localparam logic        IFEED_SEL_DEF = 1'b0;
  localparam logic [2:0]  MODE_MAX    = 3'h6;
  // ---------------------------------------------
  // motion kinds
  // ---------------------------------------------
  typedef enum logic [2:0] {
    MV_IDLE  = 3'b000,
    MV_HOME  = 3'b001,
    MV_HOMEP = 3'b010,
    MV_POS   = 3'b011,
    MV_IFEED = 3'b100,
    MV_ICRP  = 3'b101
  } smcd_mv_t;
endpackage : smcd_pkg

// ### rtl/smcd_clamp.sv
`timescale 1ns/1ps
module smcd_clamp #(
  parameter int unsigned W = 18
) (
  input  wire logic [W-1:0] val_i,
  input  wire logic [W-1:0] lo_i,
  input  wire logic [W-1:0] hi_i,
  output logic      [W-1:0] val_o
);
  // out-of-range settings saturate rather than being dropped
  always_comb begin
    if (val_i < lo_i) begin
      val_o = lo_i;
    end else if (val_i > hi_i) begin
      val_o = hi_i;
    end else begin
      val_o = val_i;
    end
  end
endmodule : smcd_clamp

// ### dv/smcd_master_model.sv
`timescale 1ns/1ps
module smcd_master_model (
  input  wire logic        mclk_i,
  output logic      [63:0] msg_o,
  output logic             msg_valid_o
);
  initial begin
    msg_o       = 64'h0000_0000_0000_0000;
    msg_valid_o = 1'b0;
  end
  // ---------------------------------------------
  // one valid sample per message
  // ---------------------------------------------
  task automatic send(input logic [63:0] m);
    @(posedge mclk_i);
    msg_o       <= m;
    msg_valid_o <= 1'b1;
    @(posedge mclk_i);
    msg_valid_o <= 1'b0;
    msg_o       <= ~m;  // stale bytes not trusted once valid drops
    #1;
  endtask : send
endmodule : smcd_master_model

// ### dv/servo_motion_command_decoder_test.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) n_compared++; if ((g) !== (e)) begin errors++; $display("wrong value %s %h %h", nm, e, g); end
module servo_motion_command_decoder_test;
  logic        mclk, arst_n, msg_valid, abs_sys, intr_in, done, hdir, fsel;
  logic        mstart, busy, dir, ifeed_en, rej;
  logic [63:0] msg;
  logic [31:0] pos, idist, target;
  logic [17:0] ispd, crawl;
  logic [9:0]  etc, mtc, etc_o, mtc_o;
  logic [2:0]  mode, kind, smode;
  int          errors, n_compared;

  smcd_master_model master (.mclk_i(mclk), .msg_o(msg), .msg_valid_o(msg_valid));
  smcd_decoder uut (.mclk_i(mclk), .arst_n_i(arst_n), .msg_i(msg), .msg_valid_i(msg_valid),
    .present_pos_i(pos), .abs_system_i(abs_sys), .intr_in_i(intr_in), .motion_done_i(done),
    .origin_search_mode_sel_i(mode), .home_dir_i(hdir), .interrupt_position_speed_i(ispd),
    .interrupt_feed_distance_i(idist), .interrupt_feed_function_sel_i(fsel),
    .exp_curve_time_constant_i(etc), .moving_avg_time_constant_i(mtc), .move_start_o(mstart),
    .move_kind_o(kind), .busy_o(busy), .target_o(target), .dir_o(dir), .search_mode_o(smode),
    .crawl_speed_o(crawl), .exp_tc_o(etc_o), .mavg_tc_o(mtc_o), .ifeed_en_o(ifeed_en),
    .cmd_reject_o(rej));

  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  function automatic logic [63:0] mk(input logic st, sv, input logic [3:0] cd, input logic hm, rl,
                                     input logic [31:0] t);
    mk = {t, 7'h00, rl, hm, 7'h00, 4'h0, cd, 6'h00, sv, st};
  endfunction : mk

  task automatic expect_move(input logic s, input logic r, input logic [2:0] k);
    `CHK("move_start", s, mstart)
    `CHK("reject", r, rej)
    `CHK("kind", k, kind)
  endtask : expect_move

  task automatic summarize();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // generous: the sequence needs well under a hundred cycles
  initial begin
    repeat (5000) @(posedge mclk);
    errors++;
    summarize();
  end

  // ---------------------------------------------
  // tests
  // ---------------------------------------------
  initial begin
    errors = 0; n_compared = 0; arst_n = 1'b0; abs_sys = 1'b0; intr_in = 1'b0; done = 1'b0;
    hdir = 1'b1; mode = 3'h7; fsel = 1'b1; pos = 32'h0000_0100; idist = 32'h0000_0040;
    ispd = 18'h0_0000; etc = 10'h002; mtc = 10'h3FF;
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    `CHK("busy", 1'b0, busy)
    `CHK("crawl_lo", smcd_pkg::SPEED_MIN, crawl)
    `CHK("exp_lo", smcd_pkg::TC_MIN, etc_o)
    `CHK("mavg_hi", smcd_pkg::TC_MAX, mtc_o)
    @(posedge mclk);
    fsel <= 1'b0; ispd <= 18'h3_FFFF; etc <= 10'h3FF; mtc <= 10'h002;
    @(posedge mclk);
    #1;
    `CHK("ifeed_en", 1'b1, ifeed_en)
    `CHK("crawl_hi", smcd_pkg::SPEED_MAX, crawl)
    `CHK("exp_hi", smcd_pkg::TC_MAX, etc_o)
    `CHK("mavg_lo", smcd_pkg::TC_MIN, mtc_o)
    master.send(mk(1'b0, 1'b1, smcd_pkg::CODE_NOP, 1'b0, 1'b0, 32'h0));
    master.send(mk(1'b1, 1'b1, smcd_pkg::CODE_DIRECT, 1'b0, 1'b0, 32'hFFFF_FFF0));
    expect_move(1'b1, 1'b0, 3'h3);
    `CHK("abs_target", 32'hFFFF_FFF0, target)
    master.send(mk(1'b1, 1'b1, smcd_pkg::CODE_DIRECT, 1'b0, 1'b1, 32'h0000_0010));
    expect_move(1'b0, 1'b0, 3'h3);
    master.send(mk(1'b0, 1'b1, smcd_pkg::CODE_DIRECT, 1'b0, 1'b1, 32'h0000_0010));
    master.send(mk(1'b1, 1'b1, smcd_pkg::CODE_DIRECT, 1'b0, 1'b1, 32'h0000_0010));
    `CHK("rel_target", pos + 32'h0000_0010, target)
    master.send(mk(1'b0, 1'b0, smcd_pkg::CODE_DIRECT, 1'b0, 1'b0, 32'h0));
    master.send(mk(1'b1, 1'b0, smcd_pkg::CODE_DIRECT, 1'b1, 1'b0, 32'h0));
    expect_move(1'b0, 1'b1, 3'h3);
    // origin bit must drop for one valid message before it counts again
    master.send(mk(1'b0, 1'b1, smcd_pkg::CODE_NOP, 1'b0, 1'b0, 32'h0));
    master.send(mk(1'b0, 1'b1, smcd_pkg::CODE_NOP, 1'b1, 1'b0, 32'h0));
    expect_move(1'b1, 1'b0, 3'h1);
    `CHK("home_dir", hdir, dir)
    `CHK("home_mode", smcd_pkg::MODE_MAX, smode)
    @(posedge mclk);
    abs_sys <= 1'b1;
    master.send(mk(1'b0, 1'b1, smcd_pkg::CODE_NOP, 1'b0, 1'b0, 32'h0));
    master.send(mk(1'b0, 1'b1, smcd_pkg::CODE_NOP, 1'b1, 1'b0, 32'h0));
    expect_move(1'b1, 1'b0, 3'h2);
    `CHK("abs_home_target", 32'h0, target)
    @(posedge mclk);
    done <= 1'b1;
    @(posedge mclk);
    done <= 1'b0;
    #1;
    `CHK("idle_busy", 1'b0, busy)
    @(posedge mclk);
    abs_sys <= 1'b0;
    master.send(mk(1'b0, 1'b1, smcd_pkg::CODE_NOP, 1'b0, 1'b0, 32'h0));
    master.send(mk(1'b1, 1'b1, smcd_pkg::CODE_IFEED, 1'b0, 1'b0, 32'h0000_2000));
    expect_move(1'b1, 1'b0, 3'h4);
    `CHK("feed_ramp", smcd_pkg::TC_MAX, etc_o)
    @(posedge mclk);
    intr_in <= 1'b1;
    // launch pulse of the feed command has already dropped in this time step
    #1;
    for (int i = 0; i < 8 && mstart !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    expect_move(1'b1, 1'b0, 3'h5);
    `CHK("crawl_target", pos + idist, target)
    master.send(mk(1'b0, 1'b1, smcd_pkg::CODE_NOP, 1'b0, 1'b0, 32'h0));
    master.send(mk(1'b1, 1'b1, 4'h3, 1'b0, 1'b0, 32'h0));
    expect_move(1'b0, 1'b1, 3'h5);
    summarize();
  end
endmodule : servo_motion_command_decoder_test
